/* File: design/cbol_loader.sv */
// Configuration byte store, its access paths and the option decode.
// Assumes programmer and self-programming requests are already on the
// core clock; the brownout comparator level is asynchronous.
//
// Contract
// - Boot bit picks application or bootloader flash.
// - Debug bit low enables on-chip debugger; here only while the chip is unlocked.
// - Reset pin bit high keeps pin as reset.
// - Locked chip reads FFH, ignores external programming.
// - Config bytes readable, not individually writable locked.
// - Whole chip erase unlocks and erases everything.
// - Lock leaves self-programming unaffected.
// - Boot area size field decodes to 0-4K.
// - Boot area byte defaults to all ones.
// - Brownout byte bit 7 switches detector on.
// - Threshold field selects one of four voltages.
// - Brownout can block self-programming below threshold.
// - Brownout reset bit enables brownout reset.
// - Watchdog field selects off, pausing, running.
// - Options copied to runtime bits after reset.
// - Boot and security byte reloads on any reset; the code keeps the boot bit on a software reset.
// - Brownout byte reloads on power-on only.
// - Three paths may rewrite configuration bytes; here only programmer and self-programming write the store.
`timescale 1ns/100ps
module cbol_loader
  import cbol_pkg::*;
#(
  parameter int FLASH_AW = 15
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_rst_event,
  input wire logic [1:0] i_rst_kind,
  input wire logic i_below_threshold,
  input wire logic i_prg_req,
  input wire logic [1:0] i_prg_op,
  input wire logic i_prg_cfg,
  input wire logic [FLASH_AW-1:0] i_prg_addr,
  input wire logic [7:0] i_prg_wdata,
  output logic [7:0] o_prg_rdata,
  output logic o_prg_ack,
  input wire logic i_iap_req,
  input wire logic [1:0] i_iap_op,
  input wire logic i_iap_cfg,
  input wire logic [FLASH_AW-1:0] i_iap_addr,
  input wire logic [7:0] i_iap_wdata,
  output logic [7:0] o_iap_rdata,
  output logic o_iap_ack,
  output logic o_iap_err,
  input wire logic [7:0] i_flash_rdata,
  output logic o_flash_we,
  output logic [FLASH_AW-1:0] o_flash_addr,
  output logic [7:0] o_flash_wdata,
  output logic o_flash_chip_erase,
  input wire logic i_rt_we,
  input wire logic [1:0] i_rt_sel,
  input wire logic [7:0] i_rt_wdata,
  output logic o_boot_from_app,
  output logic o_debugger_on,
  output logic o_reset_pin_is_reset,
  output logic o_chip_locked,
  output logic [2:0] o_boot_size_kb,
  output logic [4:0] o_app_size_kb,
  output logic o_bod_on,
  output logic [1:0] o_bod_threshold_sel,
  output logic o_bod_blocks_selfprog,
  output logic o_bod_reset,
  output logic o_wdt_enabled,
  output logic o_wdt_runs_in_sleep
);

  // Whole module state
  typedef struct packed {
    logic [3:0][7:0] cfg;
    logic rt_boot;
    logic rt_dbg_n;
    logic rt_rst_pin;
    logic [7:0] rt_bod;
    logic [3:0] rt_wdt;
    logic [2:0] bod_sync;
    logic below;
    logic [7:0] prg_rdata;
    logic prg_ack;
    logic [7:0] iap_rdata;
    logic iap_ack;
    logic iap_err;
    logic flash_we;
    logic [FLASH_AW-1:0] flash_addr;
    logic [7:0] flash_wdata;
    logic chip_erase;
  } cbol_state_t;

  cbol_state_t s_r;
  cbol_state_t s_nxt;
  logic locked;
  logic iap_blocked;
  logic [1:0] prg_idx;
  logic [1:0] iap_idx;

  assign locked = ~s_r.cfg[CFG_IDX_BOOT_SEC][LOCK_BIT];
  assign prg_idx = i_prg_addr[1:0];
  assign iap_idx = i_iap_addr[1:0];
  // Self-programming blocked only with detector on, block bit set and supply low
  assign iap_blocked = s_r.rt_bod[BOD_ON_BIT] & s_r.rt_bod[BOD_BLK_BIT]
                       & s_r.below;

  // Next-state logic: sync, software, programmer, self-prog, reload
  always_comb begin
    s_nxt = s_r;
    s_nxt.prg_ack = 1'b0;
    s_nxt.iap_ack = 1'b0;
    s_nxt.iap_err = 1'b0;
    s_nxt.flash_we = 1'b0;
    s_nxt.chip_erase = 1'b0;

    // Comparator level counts once stages two and three agree
    s_nxt.bod_sync = {s_r.bod_sync[1:0], i_below_threshold};
    if (s_r.bod_sync[1] == s_r.bod_sync[2]) begin
      s_nxt.below = s_r.bod_sync[2];
    end

    // Software adjusts boot, brownout and watchdog runtime bits freely
    if (i_rt_we) begin
      case (i_rt_sel)
        RT_SEL_BOOT: s_nxt.rt_boot = i_rt_wdata[BOOT_SRC_BIT];
        RT_SEL_BOD: s_nxt.rt_bod = i_rt_wdata;
        RT_SEL_WDT: s_nxt.rt_wdt = i_rt_wdata[WDT_LSB +: 4];
        default: ;
      endcase
    end

    // External programmer path
    if (i_prg_req) begin
      s_nxt.prg_ack = 1'b1;
      case (cbol_op_t'(i_prg_op))
        OP_READ: begin
          if (i_prg_cfg) begin
            s_nxt.prg_rdata = s_r.cfg[prg_idx];
          end else if (locked) begin
            s_nxt.prg_rdata = LOCKED_READ;
          end else begin
            s_nxt.prg_rdata = i_flash_rdata;
          end
        end
        OP_PROG: begin
          if (!locked && i_prg_cfg) begin
            // Programming only clears bits
            s_nxt.cfg[prg_idx] = s_r.cfg[prg_idx] & i_prg_wdata;
          end else if (!locked) begin
            s_nxt.flash_we = 1'b1;
            s_nxt.flash_addr = i_prg_addr;
            s_nxt.flash_wdata = i_prg_wdata;
          end
        end
        OP_ERASE: begin
          if (!locked && i_prg_cfg) begin
            s_nxt.cfg[prg_idx] = ERASED_BYTE;
          end
        end
        OP_CHIP_ERASE: begin
          // Programmer's only way out of lock; wipes flash and all options
          s_nxt.cfg = {4{ERASED_BYTE}};
          s_nxt.chip_erase = 1'b1;
        end
        default: ;
      endcase
    end

    // Self-programming path, lock is ignored here
    if (i_iap_req) begin
      s_nxt.iap_ack = 1'b1;
      if (cbol_op_t'(i_iap_op) == OP_READ) begin
        s_nxt.iap_rdata = i_iap_cfg ? s_r.cfg[iap_idx] : i_flash_rdata;
      end else if (i_prg_req || iap_blocked ||
                   cbol_op_t'(i_iap_op) == OP_CHIP_ERASE) begin
        s_nxt.iap_err = 1'b1;
      end else if (i_iap_cfg) begin
        if (cbol_op_t'(i_iap_op) == OP_PROG) begin
          s_nxt.cfg[iap_idx] = s_r.cfg[iap_idx] & i_iap_wdata;
        end else begin
          s_nxt.cfg[iap_idx] = ERASED_BYTE;
        end
      end else if (cbol_op_t'(i_iap_op) == OP_PROG) begin
        s_nxt.flash_we = 1'b1;
        s_nxt.flash_addr = i_iap_addr;
        s_nxt.flash_wdata = i_iap_wdata;
      end
    end

    // Reset events reload runtime bits; reload beats software write
    if (i_rst_event) begin
      s_nxt.rt_dbg_n = s_r.cfg[CFG_IDX_BOOT_SEC][DBG_N_BIT];
      s_nxt.rt_rst_pin = s_r.cfg[CFG_IDX_BOOT_SEC][RST_PIN_BIT];
      s_nxt.rt_wdt = s_r.cfg[CFG_IDX_WATCHDOG][WDT_LSB +: 4];
      if (cbol_rst_t'(i_rst_kind) != RST_SOFTWARE) begin
        s_nxt.rt_boot = s_r.cfg[CFG_IDX_BOOT_SEC][BOOT_SRC_BIT];
      end
      if (cbol_rst_t'(i_rst_kind) == RST_POWER_ON) begin
        s_nxt.rt_bod = s_r.cfg[CFG_IDX_BROWNOUT];
      end
    end
  end

  // State register; erased store and erased-image runtime bits
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r.cfg <= {ERASED_BYTE, ERASED_BYTE, BOOT_AREA_RESET,
                  ERASED_BYTE};
      s_r.rt_boot <= 1'b1;
      s_r.rt_dbg_n <= 1'b1;
      s_r.rt_rst_pin <= 1'b1;
      s_r.rt_bod <= ERASED_BYTE;
      s_r.rt_wdt <= WDT_OFF;
      s_r.bod_sync <= 3'h0;
      s_r.below <= 1'b0;
      s_r.prg_rdata <= 8'h00;
      s_r.prg_ack <= 1'b0;
      s_r.iap_rdata <= 8'h00;
      s_r.iap_ack <= 1'b0;
      s_r.iap_err <= 1'b0;
      s_r.flash_we <= 1'b0;
      s_r.flash_addr <= '0;
      s_r.flash_wdata <= 8'h00;
      s_r.chip_erase <= 1'b0;
    end else if (i_clk_en) begin
      s_r <= s_nxt;
    end
  end

  // Boot area size decode
  always_comb begin
    case (s_r.cfg[CFG_IDX_BOOT_AREA][BOOT_SIZE_LSB +: 3])
      3'h7: o_boot_size_kb = BOOT_KB_NONE;
      3'h6: o_boot_size_kb = BOOT_KB_1;
      3'h5: o_boot_size_kb = BOOT_KB_2;
      3'h4: o_boot_size_kb = BOOT_KB_3;
      default: o_boot_size_kb = BOOT_KB_4;
    endcase
  end
  // Application area shrinks by the boot area
  assign o_app_size_kb = FLASH_TOTAL_KB - {2'h0, o_boot_size_kb};

  // Port outputs
  assign o_prg_rdata = s_r.prg_rdata;
  assign o_prg_ack = s_r.prg_ack;
  assign o_iap_rdata = s_r.iap_rdata;
  assign o_iap_ack = s_r.iap_ack;
  assign o_iap_err = s_r.iap_err;
  assign o_flash_we = s_r.flash_we;
  assign o_flash_addr = s_r.flash_addr;
  assign o_flash_wdata = s_r.flash_wdata;
  assign o_flash_chip_erase = s_r.chip_erase;

  // Option outputs
  assign o_boot_from_app = s_r.rt_boot;
  assign o_debugger_on = ~s_r.rt_dbg_n & ~locked;
  assign o_reset_pin_is_reset = s_r.rt_rst_pin;
  assign o_chip_locked = locked;
  assign o_bod_on = s_r.rt_bod[BOD_ON_BIT];
  assign o_bod_threshold_sel = s_r.rt_bod[BOD_THR_LSB +: 2];
  assign o_bod_blocks_selfprog = iap_blocked;
  assign o_bod_reset = s_r.rt_bod[BOD_ON_BIT] & s_r.rt_bod[BOD_RST_BIT]
                       & s_r.below;
  assign o_wdt_enabled = s_r.rt_wdt != WDT_OFF;
  assign o_wdt_runs_in_sleep = (s_r.rt_wdt != WDT_OFF) &&
                               (s_r.rt_wdt != WDT_PAUSE);

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  property p_boot_reload;
    i_clk_en && i_rst_event && i_rst_kind != RST_SOFTWARE
    |=> o_boot_from_app == $past(s_r.cfg[0][BOOT_SRC_BIT]);
  endproperty
  a_boot_reload: assert property (p_boot_reload)
    else $error("boot source not reloaded");

  property p_rst_pin_reload;
    i_clk_en && i_rst_event
    |=> o_reset_pin_is_reset == $past(s_r.cfg[0][RST_PIN_BIT]);
  endproperty
  a_rst_pin_reload: assert property (p_rst_pin_reload)
    else $error("reset pin function not reloaded");

  property p_locked_read;
    i_clk_en && i_prg_req && i_prg_op == OP_READ && !i_prg_cfg && locked
    |=> o_prg_ack && o_prg_rdata == LOCKED_READ;
  endproperty
  a_locked_read: assert property (p_locked_read)
    else $error("locked flash read not blank");

  property p_locked_prog;
    i_clk_en && i_prg_req && i_prg_op == OP_PROG && locked && !i_iap_req
    |=> !o_flash_we && $stable(s_r.cfg);
  endproperty
  a_locked_prog: assert property (p_locked_prog)
    else $error("locked chip accepted programming");

  property p_chip_erase;
    i_clk_en && i_prg_req && i_prg_op == OP_CHIP_ERASE
    |=> o_flash_chip_erase && !o_chip_locked;
  endproperty
  a_chip_erase: assert property (p_chip_erase)
    else $error("chip erase did not unlock");

  property p_iap_locked;
    i_clk_en && i_iap_req && i_iap_op == OP_PROG && !i_iap_cfg
    && !i_prg_req && !iap_blocked
    |=> o_flash_we && o_iap_ack && !o_iap_err;
  endproperty
  a_iap_locked: assert property (p_iap_locked)
    else $error("self-programming write lost");

  property p_app_size;
    o_app_size_kb + {2'h0, o_boot_size_kb} == FLASH_TOTAL_KB
    && o_boot_size_kb <= BOOT_KB_4;
  endproperty
  a_app_size: assert property (p_app_size)
    else $error("flash split wrong");

  property p_iap_block;
    i_clk_en && i_iap_req && i_iap_op == OP_PROG && iap_blocked
    && !i_prg_req
    |=> o_iap_err && o_iap_ack && !o_flash_we && $stable(s_r.cfg);
  endproperty
  a_iap_block: assert property (p_iap_block)
    else $error("brownout did not block self-programming");

  property p_bod_kept;
    i_clk_en && i_rst_event && i_rst_kind != RST_POWER_ON && !i_rt_we
    |=> $stable(s_r.rt_bod);
  endproperty
  a_bod_kept: assert property (p_bod_kept)
    else $error("brownout byte reloaded on warm reset");

  property p_wdt_mode;
    s_r.rt_wdt == WDT_PAUSE |-> o_wdt_enabled && !o_wdt_runs_in_sleep;
  endproperty
  a_wdt_mode: assert property (p_wdt_mode)
    else $error("watchdog mode decode wrong");

endmodule // cbol_loader

/* File: design/cbol_pkg.sv */
// Package of the configuration byte option loader: byte indices, bit
// positions, erased values, decode codes and the access operations.
// Assumes a single 50 MHz core clock domain for all users.
package cbol_pkg;

  // Configuration byte indices inside the store
  localparam logic [1:0] CFG_IDX_BOOT_SEC = 2'h0;
  localparam logic [1:0] CFG_IDX_BOOT_AREA = 2'h1;
  localparam logic [1:0] CFG_IDX_BROWNOUT = 2'h2;
  localparam logic [1:0] CFG_IDX_WATCHDOG = 2'h3;

  // Boot and security byte fields
  localparam int BOOT_SRC_BIT = 7;
  localparam int DBG_N_BIT = 4;
  localparam int RST_PIN_BIT = 2;
  localparam int LOCK_BIT = 1;

  // Boot area byte field
  localparam int BOOT_SIZE_LSB = 0;

  // Brownout byte fields
  localparam int BOD_ON_BIT = 7;
  localparam int BOD_THR_LSB = 4;
  localparam int BOD_BLK_BIT = 3;
  localparam int BOD_RST_BIT = 2;

  // Watchdog byte field
  localparam int WDT_LSB = 4;

  // Erased, locked-read and reset values
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] LOCKED_READ = 8'hff;
  localparam logic [7:0] BOOT_AREA_RESET = 8'hff;

  // Watchdog mode codes
  localparam logic [3:0] WDT_OFF = 4'hf;
  localparam logic [3:0] WDT_PAUSE = 4'h5;

  // Boot area sizes in kilobytes and the full flash size
  localparam logic [4:0] FLASH_TOTAL_KB = 5'h12;
  localparam logic [2:0] BOOT_KB_NONE = 3'h0;
  localparam logic [2:0] BOOT_KB_1 = 3'h1;
  localparam logic [2:0] BOOT_KB_2 = 3'h2;
  localparam logic [2:0] BOOT_KB_3 = 3'h3;
  localparam logic [2:0] BOOT_KB_4 = 3'h4;

  // Runtime control selects for software writes
  localparam logic [1:0] RT_SEL_BOOT = 2'h0;
  localparam logic [1:0] RT_SEL_BOD = 2'h2;
  localparam logic [1:0] RT_SEL_WDT = 2'h3;

  // Access operations of the programmer and self-programming ports
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_PROG = 2'h1,
    OP_ERASE = 2'h2,
    OP_CHIP_ERASE = 2'h3
  } cbol_op_t;

  // Kinds of reset event
  typedef enum logic [1:0] {
    RST_POWER_ON = 2'h0,
    RST_PIN = 2'h1,
    RST_SOFTWARE = 2'h2,
    RST_OTHER = 2'h3
  } cbol_rst_t;

endpackage

/* File: tb/cbol_flash_model.sv */
// Flash array model standing behind the loader's flash port.
// Assumes byte writes and whole erase arrive as one-cycle pulses.
`timescale 1ns/100ps
module cbol_flash_model (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [14:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic i_chip_erase,
  input wire logic [14:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [16];
  // Array starts erased
  initial begin
    foreach (mem[k]) mem[k] = 8'hff;
  end
  // Read path follows the address at once
  assign o_rdata = mem[i_raddr[3:0]];
  // Whole erase wins over a byte write
  always @(posedge i_core_clk) begin
    if (i_chip_erase) begin
      foreach (mem[k]) mem[k] <= 8'hff;
    end else if (i_we) begin
      mem[i_waddr[3:0]] <= i_wdata;
    end
  end
endmodule // cbol_flash_model

/* File: tb/cbol_loader_test.sv */
// Self-checking bench of the configuration byte option loader.
// Assumes one 50 MHz clock; inputs move on the falling edge.
`timescale 1ns/100ps
module cbol_loader_test;
  import cbol_pkg::*;
  logic i_core_clk = 0, i_reset = 1, i_clk_en = 1;
  logic i_rst_event = 0, i_below_threshold = 0, i_rt_we = 0;
  logic [1:0] i_rst_kind = 0, i_rt_sel = 0, i_prg_op = 0, i_iap_op = 0;
  logic i_prg_req = 0, i_prg_cfg = 0, i_iap_req = 0, i_iap_cfg = 0;
  logic [14:0] i_prg_addr = 0, i_iap_addr = 0, o_flash_addr;
  logic [7:0] i_prg_wdata = 0, i_iap_wdata = 0, i_rt_wdata = 0;
  logic [7:0] o_prg_rdata, o_iap_rdata, i_flash_rdata, o_flash_wdata;
  logic o_prg_ack, o_iap_ack, o_iap_err, o_flash_we, o_flash_chip_erase;
  logic o_boot_from_app, o_debugger_on, o_reset_pin_is_reset;
  logic o_chip_locked, o_bod_on, o_bod_blocks_selfprog, o_bod_reset;
  logic [2:0] o_boot_size_kb;
  logic [4:0] o_app_size_kb;
  logic [1:0] o_bod_threshold_sel;
  logic o_wdt_enabled, o_wdt_runs_in_sleep, er;
  logic [7:0] rd;
  int bad_count = 0, n_checks = 0;

  cbol_loader uut (.i_core_clk, .i_reset, .i_clk_en, .i_rst_event,
    .i_rst_kind, .i_below_threshold, .i_prg_req, .i_prg_op, .i_prg_cfg,
    .i_prg_addr, .i_prg_wdata, .o_prg_rdata, .o_prg_ack, .i_iap_req,
    .i_iap_op, .i_iap_cfg, .i_iap_addr, .i_iap_wdata, .o_iap_rdata,
    .o_iap_ack, .o_iap_err, .i_flash_rdata, .o_flash_we, .o_flash_addr,
    .o_flash_wdata, .o_flash_chip_erase, .i_rt_we, .i_rt_sel, .i_rt_wdata,
    .o_boot_from_app, .o_debugger_on, .o_reset_pin_is_reset,
    .o_chip_locked, .o_boot_size_kb, .o_app_size_kb, .o_bod_on,
    .o_bod_threshold_sel, .o_bod_blocks_selfprog, .o_bod_reset,
    .o_wdt_enabled, .o_wdt_runs_in_sleep);

  cbol_flash_model flash (.i_core_clk, .i_we(o_flash_we),
    .i_waddr(o_flash_addr), .i_wdata(o_flash_wdata),
    .i_chip_erase(o_flash_chip_erase),
    .i_raddr(i_prg_req ? i_prg_addr : i_iap_addr), .o_rdata(i_flash_rdata));

  // Free-running core clock
  initial begin
    forever #10 i_core_clk = ~i_core_clk;
  end

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // Runtime option outputs packed for one compare
  function automatic logic [7:0] sa();
    return {o_boot_from_app, o_debugger_on, o_reset_pin_is_reset,
      o_chip_locked, o_bod_on, o_bod_blocks_selfprog, o_bod_reset,
      o_wdt_enabled};
  endfunction

  // One access on the programmer port or the self-programming port
  task automatic acc(bit in_application_programming, logic [1:0] op, bit cfg, logic [14:0] a,
                     logic [7:0] wd);
    int k;
    if (in_application_programming) begin
      {i_iap_req, i_iap_op, i_iap_cfg, i_iap_addr, i_iap_wdata} =
        {1'b1, op, cfg, a, wd};
    end else begin
      {i_prg_req, i_prg_op, i_prg_cfg, i_prg_addr, i_prg_wdata} =
        {1'b1, op, cfg, a, wd};
    end
    tick(1);
    i_iap_req = 0;
    i_prg_req = 0;
    k = 0;
    while (k < 8 && (in_application_programming ? o_iap_ack : o_prg_ack) !== 1'b1) begin
      tick(1);
      k++;
    end
    if (k == 8) begin
      bad_count++;
      complete_run();
    end
    rd = in_application_programming ? o_iap_rdata : o_prg_rdata;
    er = o_iap_err;
    tick(1);
  endtask

  task automatic rst_ev(logic [1:0] kind);
    {i_rst_event, i_rst_kind} = {1'b1, kind};
    tick(1);
    i_rst_event = 0;
    tick(1);
  endtask

  task automatic rt_wr(logic [1:0] sel, logic [7:0] wd);
    {i_rt_we, i_rt_sel, i_rt_wdata} = {1'b1, sel, wd};
    tick(1);
    i_rt_we = 0;
    tick(1);
  endtask

  task automatic t_defaults();
    for (int i = 0; i < 4; i++) begin
      acc(0, OP_READ, 1, 15'(i), 8'h00);
      chk("cfg erased", rd, ERASED_BYTE);
    end
    chk("opts", sa(), 8'ha8);
    chk("size", {o_boot_size_kb, o_app_size_kb}, 8'h12);
    chk("thr", {6'h0, o_bod_threshold_sel}, 8'h03);
  endtask

  task automatic t_boot_area();
    logic [2:0] c;
    int e;
    for (int i = 7; i >= 0; i--) begin
      c = 3'(i);
      acc(c[0], OP_ERASE, 1, 15'(CFG_IDX_BOOT_AREA), 8'h00);
      acc(c[1], OP_PROG, 1, 15'(CFG_IDX_BOOT_AREA), {5'h1f, c});
      e = c[2] ? 3 - int'(c[1:0]) : 4;
      chk("size", {o_boot_size_kb, o_app_size_kb}, {3'(e), 5'(18-e)});
    end
  endtask

  task automatic t_reload();
    acc(0, OP_PROG, 1, 15'(CFG_IDX_BOOT_SEC), 8'h6b);
    acc(0, OP_PROG, 1, 15'(CFG_IDX_BROWNOUT), 8'hcf);
    acc(0, OP_PROG, 1, 15'(CFG_IDX_WATCHDOG), 8'h5f);
    chk("no reload", sa(), 8'ha8);
    rst_ev(RST_SOFTWARE);
    chk("sw reset", sa(), 8'hc9);
    chk("thr", {6'h0, o_bod_threshold_sel}, 8'h03);
    rst_ev(RST_PIN);
    chk("pin reset", sa(), 8'h49);
    chk("wdt", {6'h0, o_wdt_enabled, o_wdt_runs_in_sleep}, 8'h02);
    rst_ev(RST_POWER_ON);
    chk("thr", {6'h0, o_bod_threshold_sel}, 8'h00);
    i_below_threshold = 1;
    tick(5);
    chk("below", sa(), 8'h4f);
    acc(1, OP_PROG, 0, 15'h5, 8'h00);
    chk("iap err", {7'h0, er}, 8'h01);
    rt_wr(RT_SEL_BOD, 8'h7f);
    chk("bod off", sa(), 8'h41);
    for (int t = 0; t < 4; t++) begin
      rt_wr(RT_SEL_BOD, {2'b11, 2'(t), 4'hf});
      chk("thr", {6'h0, o_bod_threshold_sel}, 8'(t));
    end
    i_below_threshold = 0;
    tick(5);
    rt_wr(RT_SEL_WDT, 8'hf0);
    chk("wdt off", {7'h0, o_wdt_enabled}, 8'h00);
    rt_wr(RT_SEL_WDT, 8'h30);
    chk("wdt run", {6'h0, o_wdt_enabled, o_wdt_runs_in_sleep}, 8'h03);
    rt_wr(RT_SEL_BOOT, 8'h80);
    chk("boot sw", {7'h0, o_boot_from_app}, 8'h01);
    rst_ev(RST_OTHER);
    chk("other rst", {5'h0, o_boot_from_app, o_bod_threshold_sel}, 8'h03);
  endtask

  task automatic t_lock();
    acc(0, OP_PROG, 0, 15'h3, 8'h5a);
    acc(0, OP_READ, 0, 15'h3, 8'h00);
    chk("flash rd", rd, 8'h5a);
    acc(1, OP_PROG, 1, 15'(CFG_IDX_BOOT_SEC), 8'hfd);
    chk("lock", {6'h0, o_chip_locked, o_debugger_on}, 8'h02);
    acc(0, OP_READ, 0, 15'h3, 8'h00);
    chk("locked rd", rd, LOCKED_READ);
    acc(0, OP_PROG, 0, 15'h3, 8'h00);
    chk("prog ignored", flash.mem[3], 8'h5a);
    acc(0, OP_ERASE, 1, 15'(CFG_IDX_BOOT_SEC), 8'h00);
    acc(0, OP_READ, 1, 15'(CFG_IDX_BOOT_SEC), 8'h00);
    chk("cfg kept", rd, 8'h69);
    acc(1, OP_READ, 0, 15'h3, 8'h00);
    chk("iap rd", rd, 8'h5a);
    acc(1, OP_PROG, 0, 15'h4, 8'h33);
    chk("iap wr", flash.mem[4], 8'h33);
    acc(1, OP_CHIP_ERASE, 0, 15'h0, 8'h00);
    chk("iap erase", {6'h0, er, o_chip_locked}, 8'h03);
    acc(0, OP_CHIP_ERASE, 0, 15'h0, 8'h00);
    chk("unlock", {7'h0, o_chip_locked}, 8'h00);
    acc(0, OP_READ, 1, 15'(CFG_IDX_BOOT_SEC), 8'h00);
    chk("cfg wiped", rd, ERASED_BYTE);
    acc(0, OP_READ, 0, 15'h3, 8'h00);
    chk("flash wiped", rd, ERASED_BYTE);
  endtask

  // Reset, then the scenarios in order
  initial begin
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_reset = 0;
    tick(1);
    t_defaults();
    t_boot_area();
    t_reload();
    t_lock();
    complete_run();
  end
endmodule // cbol_loader_test
